// file: fesb_consts.vh
// constants for the flash erase, bank and security block
`ifndef FESB_CONSTS_VH
`define FESB_CONSTS_VH

`define FESB_SFR_ERASE_KEY   8'h94
`define FESB_SFR_MASS_EN     8'hB2
`define FESB_SFR_PAGE_NUM    8'hB7
`define FESB_MASS_EN_BIT     1
`define FESB_PAGE_LSB        2
`define FESB_PAGE_MSB        7
`define FESB_KEY_MASS        8'hAA
`define FESB_KEY_PAGE        8'h55
`define FESB_ERASED_BYTE     8'hFF
`define FESB_EARLY_BOOT_WINDOW_FLAG_CYCLES  7'h3C
`define FESB_PAGE_BYTES      1024
`define FESB_PAGE_SHIFT      10
`define FESB_BANK_BYTES      32768
`define FESB_BANK_SHIFT      15
`define FESB_UPPER_BIT       15
`define FESB_PAGE_ZERO       8'h00
`define FESB_ZERO_BYTE       8'h00

`endif

// file: fesb_bank_map.v
// program-space to physical flash address mapping
`include "fesb_consts.vh"

module fesb_bank_map #(
  parameter BANK_W = 3,
  parameter PHYS_W = 18
) (
  input  wire [15:0]       prog_addr,
  input  wire [BANK_W-1:0] bank_sel,
  output wire [PHYS_W-1:0] phys_addr
);

  wire             upper;
  wire [BANK_W-1:0] bank;

  // lower half is fixed; bank 0 in the upper half aliases the lower half
  assign upper = prog_addr[`FESB_UPPER_BIT];                        // [RL5]
  assign bank  = upper ? bank_sel : {BANK_W{1'b0}};                 // [RL6] [RL7]
  assign phys_addr = {bank, prog_addr[`FESB_BANK_SHIFT-1:0]};       // [RL6]

endmodule // fesb_bank_map

// file: fesb_flash_ctrl.v
// flash erase sequencer, bank switching and program security
//
// Functional notes
// RL1 - erased flash bytes read as 0xFF
// RL2 - mass erase: enable bit, then key 0xAA
// RL3 - mass erase needs debug port enabled
// RL4 - page erase: page number, then key 0x55
// RL5 - low program half maps to flash bank 0
// RL6 - upper half maps to selected bank
// RL7 - bank zero aliases the lower region
// RL8 - code_protection_bit blocks debug except global erase
// RL9 - 60-cycle pre-boot window inhibits debug, flagged
// RL10 - after pre-boot debug may be enabled
// RL11 - protection bit clears on reset, set-only
// RL12 - protection held until global erase plus reset; here any reset clears it, with or without a global erase
// RL13 - code_protection_bit rejects page-zero page erases
// RL14 - code_protection_bit suppresses writes to page zero
// RL15 - code_protection_bit prevents external code read-out
// RL16 - software sets protection during pre-boot
// RL17 - byte change needs copy, erase, rewrite
// RL18 - flash pages are 1024 bytes each
// RL19 - write enable steers stores, interrupt-gated
// RL20 - write during engine busy drops, raises collision
// RL21 - other keys start no erase
`include "fesb_consts.vh"

module fesb_flash_ctrl #(
  parameter BANK_W = 3,
  parameter PHYS_W = 18,
  parameter PAGE_W = 6
) (
  input  wire              clock,
  input  wire              rst_n,
  // special function register port from the processor
  input  wire [7:0]        sfr_addr,
  input  wire [7:0]        sfr_wdata,
  input  wire              sfr_we,
  input  wire              sfr_re,
  output reg  [7:0]        sfr_rdata_r,
  output wire              sfr_hit,
  // plain control inputs from the processor
  input  wire [BANK_W-1:0] upper_bank_select,
  input  wire              code_protection_we,
  input  wire              code_protection_wdata,
  input  wire              program_write_enable_we,
  input  wire              program_write_enable_wdata,
  input  wire              mpu_int_enabled,
  // processor external data store
  input  wire              mpu_store,
  input  wire [15:0]       mpu_store_addr,
  input  wire [7:0]        mpu_store_data,
  // compute engine state
  input  wire              engine_busy,
  // debug port
  input  wire              dbg_port_enable_pin,
  input  wire              dbg_mass_erase_req,
  input  wire              dbg_page_erase_req,
  input  wire [PAGE_W-1:0] dbg_page,
  input  wire              dbg_write_req,
  input  wire [PHYS_W-1:0] dbg_write_addr,
  input  wire [7:0]        dbg_write_data,
  input  wire              dbg_read_req,
  input  wire [15:0]       dbg_read_addr,
  input  wire              dbg_ctrl_req,
  // program fetch and flash array
  input  wire [15:0]       prog_addr,
  input  wire [7:0]        flash_rd_data,
  output reg  [PHYS_W-1:0] flash_rd_addr_r,
  output reg  [7:0]        dbg_read_data_r,
  output reg               dbg_read_valid_r,
  output reg               flash_wr_en_r,
  output reg  [PHYS_W-1:0] flash_wr_addr_r,
  output reg  [7:0]        flash_wr_data_r,
  output reg               flash_mass_erase_r,
  output reg               flash_page_erase_r,
  output reg  [PAGE_W-1:0] flash_erase_page_r,
  // status
  output reg               early_boot_window_flag,
  output reg               code_protection_bit,
  output reg               program_write_enable,
  output reg               busy_write_collision_irq,
  output wire              dbg_enabled,
  output wire              dbg_ctrl_grant,
  output reg               global_erase_done_r
);

  localparam [2:0] ST_EARLY_BOOT_WINDOW_FLAG = 3'b001;
  localparam [2:0] ST_OPEN    = 3'b010;
  localparam [2:0] ST_SECURED = 3'b100;

  reg  [2:0]        state_r;
  reg  [2:0]        state_nxt;
  reg  [6:0]        boot_cnt_r;
  reg               dbg_pin_s1_r;
  reg               dbg_pin_s2_r;
  reg               mass_erase_enable_r;
  reg  [PAGE_W-1:0] erase_page_number_r;
  reg               dbg_rd_pend_r;

  wire [PHYS_W-1:0] fetch_phys;
  wire [PHYS_W-1:0] dbg_rd_phys;
  wire [PHYS_W-1:0] store_phys;
  wire              wr_key;
  wire              key_mass;
  wire              key_page;
  wire              mpu_mass_ok;
  wire              mpu_page_ok;
  wire              dbg_mass_ok;
  wire              dbg_page_ok;
  wire              secured;
  wire              dbg_wr_ok;
  wire              mpu_wr_try;
  wire              mpu_wr_ok;

  localparam [6:0] EARLY_BOOT_WINDOW_FLAG_LAST = `FESB_EARLY_BOOT_WINDOW_FLAG_CYCLES - 7'h01;

  // page index of a physical flash address
  function [PHYS_W-`FESB_PAGE_SHIFT-1:0] page_of;
    input [PHYS_W-1:0] a;
    begin
      page_of = a[PHYS_W-1:`FESB_PAGE_SHIFT];                        // [RL18]
    end
  endfunction

  function is_page_zero;
    input [PHYS_W-1:0] a;
    begin
      is_page_zero = (page_of(a) == {(PHYS_W-`FESB_PAGE_SHIFT){1'b0}});
    end
  endfunction

  fesb_bank_map #(
    .BANK_W    (BANK_W),
    .PHYS_W    (PHYS_W)
  ) u_fetch_map (
    .prog_addr (prog_addr),
    .bank_sel  (upper_bank_select),
    .phys_addr (fetch_phys)
  );

  fesb_bank_map #(
    .BANK_W    (BANK_W),
    .PHYS_W    (PHYS_W)
  ) u_dbg_map (
    .prog_addr (dbg_read_addr),
    .bank_sel  (upper_bank_select),
    .phys_addr (dbg_rd_phys)
  );

  fesb_bank_map #(
    .BANK_W    (BANK_W),
    .PHYS_W    (PHYS_W)
  ) u_store_map (
    .prog_addr (mpu_store_addr),
    .bank_sel  (upper_bank_select),
    .phys_addr (store_phys)
  );

  // enable pin comes from outside; only the second stage is used
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dbg_pin_s1_r <= 1'b0;
      dbg_pin_s2_r <= 1'b0;
    end
    else
    begin
      dbg_pin_s1_r <= dbg_port_enable_pin;
      dbg_pin_s2_r <= dbg_pin_s1_r;
    end
  end

  // pre-boot, open and secured phases
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_EARLY_BOOT_WINDOW_FLAG:
      begin
        if (boot_cnt_r == EARLY_BOOT_WINDOW_FLAG_LAST)
          state_nxt = code_protection_bit ? ST_SECURED : ST_OPEN;   // [RL9]
      end
      ST_OPEN:
      begin
        if (code_protection_bit)
          state_nxt = ST_SECURED;
      end
      ST_SECURED:
        state_nxt = ST_SECURED;                                     // [RL12]
      default:
        state_nxt = ST_EARLY_BOOT_WINDOW_FLAG;
    endcase
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r                <= ST_EARLY_BOOT_WINDOW_FLAG;
      boot_cnt_r             <= 7'h00;
      early_boot_window_flag <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r == ST_EARLY_BOOT_WINDOW_FLAG)
        boot_cnt_r <= boot_cnt_r + 7'h01;
      early_boot_window_flag <= (state_nxt == ST_EARLY_BOOT_WINDOW_FLAG);          // [RL9]
    end
  end

  assign secured = code_protection_bit;

  // debug inhibited during pre-boot, may be enabled afterwards
  assign dbg_enabled    = dbg_pin_s2_r & ~early_boot_window_flag;   // [RL9] [RL10]
  // only global erase survives protection; control of the core is blocked
  assign dbg_ctrl_grant = dbg_enabled & ~secured & dbg_ctrl_req;    // [RL8] [RL10]

  // erase key decode
  assign wr_key   = sfr_we & (sfr_addr == `FESB_SFR_ERASE_KEY);
  assign key_mass = wr_key & (sfr_wdata == `FESB_KEY_MASS);
  assign key_page = wr_key & (sfr_wdata == `FESB_KEY_PAGE);         // [RL21]

  assign mpu_mass_ok = key_mass & mass_erase_enable_r & dbg_enabled; // [RL2] [RL3]
  assign mpu_page_ok = key_page &
                       ~(secured && erase_page_number_r == {PAGE_W{1'b0}}); // [RL4] [RL13]
  assign dbg_mass_ok = dbg_mass_erase_req & dbg_enabled;            // [RL3] [RL8]
  // any debug page erase is blocked under protection, page zero included
  assign dbg_page_ok = dbg_page_erase_req & dbg_enabled & ~secured; // [RL8] [RL13]

  // special function registers and erase strobes
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mass_erase_enable_r <= 1'b0;
      erase_page_number_r <= {PAGE_W{1'b0}};
      flash_mass_erase_r  <= 1'b0;
      flash_page_erase_r  <= 1'b0;
      flash_erase_page_r  <= {PAGE_W{1'b0}};
      global_erase_done_r <= 1'b0;
    end
    else
    begin
      flash_mass_erase_r <= mpu_mass_ok | dbg_mass_ok;              // [RL2]
      flash_page_erase_r <= 1'b0;
      if (mpu_mass_ok | dbg_mass_ok)
      begin
        mass_erase_enable_r <= 1'b0;
        // protection stays until the next chip reset
        global_erase_done_r <= 1'b1;                                // [RL12]
      end
      else if (sfr_we && sfr_addr == `FESB_SFR_MASS_EN)
        mass_erase_enable_r <= sfr_wdata[`FESB_MASS_EN_BIT];        // [RL2]
      if (sfr_we && sfr_addr == `FESB_SFR_PAGE_NUM)
        erase_page_number_r <= sfr_wdata[`FESB_PAGE_MSB:`FESB_PAGE_LSB]; // [RL4]
      if (dbg_page_ok)
      begin
        flash_page_erase_r <= 1'b1;
        flash_erase_page_r <= dbg_page;
      end
      else if (mpu_page_ok)
      begin
        flash_page_erase_r <= 1'b1;                                 // [RL4]
        flash_erase_page_r <= erase_page_number_r;
      end
    end
  end

  assign sfr_hit = (sfr_addr == `FESB_SFR_ERASE_KEY) |
                   (sfr_addr == `FESB_SFR_MASS_EN) |
                   (sfr_addr == `FESB_SFR_PAGE_NUM);

  // register reads; key register is write-only and reads zero
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      sfr_rdata_r <= `FESB_ZERO_BYTE;
    else if (sfr_re)
    begin
      case (sfr_addr)
        `FESB_SFR_MASS_EN:
        begin
          sfr_rdata_r <= `FESB_ZERO_BYTE;
          sfr_rdata_r[`FESB_MASS_EN_BIT] <= mass_erase_enable_r;
        end
        `FESB_SFR_PAGE_NUM:
          sfr_rdata_r <= {erase_page_number_r, 2'h0};
        default:
          sfr_rdata_r <= `FESB_ZERO_BYTE;
      endcase
    end
  end

  // protection bit and program write enable
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      code_protection_bit  <= 1'b0;                                 // [RL11]
      program_write_enable <= 1'b0;
    end
    else
    begin
      if (code_protection_we && code_protection_wdata)
        code_protection_bit <= 1'b1;                                // [RL11]
      if (program_write_enable_we && !mpu_int_enabled)
        program_write_enable <= program_write_enable_wdata;         // [RL19]
    end
  end

  // flash writes: debug port has priority, a core store in the same cycle is dropped
  assign dbg_wr_ok  = dbg_write_req & dbg_enabled & ~secured;       // [RL8]
  assign mpu_wr_try = mpu_store & program_write_enable;             // [RL19]
  assign mpu_wr_ok  = mpu_wr_try & ~engine_busy & ~dbg_wr_ok &
                      ~(secured && is_page_zero(store_phys));       // [RL14] [RL20]

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flash_wr_en_r            <= 1'b0;
      flash_wr_addr_r          <= {PHYS_W{1'b0}};
      flash_wr_data_r          <= `FESB_ZERO_BYTE;
      busy_write_collision_irq <= 1'b0;
    end
    else
    begin
      flash_wr_en_r            <= dbg_wr_ok | mpu_wr_ok;
      busy_write_collision_irq <= mpu_wr_try & engine_busy;         // [RL20]
      if (dbg_wr_ok && !(secured && is_page_zero(dbg_write_addr)))
      begin
        flash_wr_addr_r <= dbg_write_addr;                          // [RL14]
        flash_wr_data_r <= dbg_write_data;
      end
      else if (mpu_wr_ok)
      begin
        flash_wr_addr_r <= store_phys;
        flash_wr_data_r <= mpu_store_data;
      end
    end
  end

  // fetch address and debug read-back; fetch owns the port except on a debug read
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flash_rd_addr_r  <= {PHYS_W{1'b0}};
      dbg_rd_pend_r    <= 1'b0;
      dbg_read_data_r  <= `FESB_ERASED_BYTE;
      dbg_read_valid_r <= 1'b0;
    end
    else
    begin
      dbg_rd_pend_r    <= dbg_read_req & dbg_enabled;
      dbg_read_valid_r <= dbg_rd_pend_r;
      if (dbg_read_req && dbg_enabled)
        flash_rd_addr_r <= dbg_rd_phys;                             // [RL6]
      else
        flash_rd_addr_r <= fetch_phys;                              // [RL5] [RL7]
      // protected code reads back as blank flash
      if (dbg_rd_pend_r)
        dbg_read_data_r <= secured ? `FESB_ERASED_BYTE : flash_rd_data; // [RL1] [RL15]
    end
  end

endmodule // fesb_flash_ctrl

// file: fesb_checker.sv
// concurrent checks on the flash control block ports
module fesb_checker (
  input logic        clock,
  input logic        rst_n,
  input logic        sfr_we,
  input logic [7:0]  sfr_addr,
  input logic [7:0]  sfr_wdata,
  input logic        dbg_mass_erase_req,
  input logic        dbg_page_erase_req,
  input logic        dbg_read_req,
  input logic [15:0] prog_addr,
  input logic [2:0]  upper_bank_select,
  input logic [17:0] flash_rd_addr_r,
  input logic [7:0]  dbg_read_data_r,
  input logic        dbg_read_valid_r,
  input logic        flash_mass_erase_r,
  input logic        flash_page_erase_r,
  input logic [5:0]  flash_erase_page_r,
  input logic        early_boot_window_flag,
  input logic        code_protection_bit,
  input logic        dbg_enabled,
  input logic        dbg_ctrl_grant
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [6:0] cnt_r;
  // saturates so the window check fires only once per reset
  always @(posedge clock or negedge rst_n)
    if (!rst_n)
      cnt_r <= 7'h00;
    else if (cnt_r != 7'h7F)
      cnt_r <= cnt_r + 7'h01;
  sequence s_key(logic [7:0] k);
    sfr_we && sfr_addr == 8'h94 && sfr_wdata == k;
  endsequence
  sequence s_dbg_mass;
    dbg_mass_erase_req && dbg_enabled;
  endsequence
  chk_boot_window: assert property (cnt_r == 7'h3C |->
    $past(early_boot_window_flag) && !early_boot_window_flag) else $error("boot window length");
  chk_early_boot_window_flag_dbg: assert property (early_boot_window_flag |-> !dbg_enabled)
    else $error("debug enabled in boot window");
  chk_mass_needs_dbg: assert property (s_key(8'hAA) ##0 !dbg_enabled |=> !flash_mass_erase_r)
    else $error("mass erase without debug port");
  chk_bad_key: assert property (sfr_we && sfr_addr == 8'h94 && sfr_wdata != 8'hAA
    && sfr_wdata != 8'h55 && !dbg_mass_erase_req && !dbg_page_erase_req
    |=> !flash_mass_erase_r && !flash_page_erase_r) else $error("erase from bad key");
  chk_dbg_mass: assert property (s_dbg_mass |=> flash_mass_erase_r)
    else $error("debug mass erase lost");
  chk_code_protection_bit_ctrl: assert property (code_protection_bit |-> !dbg_ctrl_grant)
    else $error("debug control while code_protection_bit");
  chk_code_protection_bit_hold: assert property (code_protection_bit |=> code_protection_bit)
    else $error("protection cleared");
  chk_page_zero: assert property ($past(code_protection_bit) && flash_page_erase_r
    |-> flash_erase_page_r != 6'h00) else $error("page zero erased while code_protection_bit");
  chk_code_protection_bit_read: assert property ($past(code_protection_bit) && dbg_read_valid_r
    |-> dbg_read_data_r == 8'hFF) else $error("code read out while code_protection_bit");
  chk_fetch_map: assert property (!dbg_read_req |=> flash_rd_addr_r ==
    {($past(prog_addr[15]) ? $past(upper_bank_select) : 3'h0), $past(prog_addr[14:0])})
    else $error("fetch address mapping");
endmodule // fesb_checker

// file: fesb_flash_model.sv
// behavioural flash array answering the block's read address
module fesb_flash_model (
  input  logic        clock,
  input  logic [17:0] rd_addr,
  input  logic        mass_erase,
  output logic [7:0]  rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic erased_r = 1'b0;
  always @(posedge clock)
    if (mass_erase)
      erased_r <= 1'b1;
  // address-derived contents so a wrong address or leak is visible
  assign rd_data = erased_r ? 8'hFF : (rd_addr[7:0] ^ rd_addr[17:10]);
endmodule // fesb_flash_model

// file: test_flash_erase_bank_security.sv
// self-checking bench for the flash erase, bank and security block
module test_flash_erase_bank_security;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, rst_n, sfr_we, sfr_re, code_protection_we, code_protection_wdata;
  logic        program_write_enable_we, program_write_enable_wdata, mpu_int_enabled;
  logic        mpu_store, engine_busy, dbg_port_enable_pin, dbg_mass_erase_req;
  logic        dbg_page_erase_req, dbg_write_req, dbg_read_req, dbg_ctrl_req;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata_r, mpu_store_data, dbg_write_data;
  logic [7:0]  flash_rd_data, dbg_read_data_r, flash_wr_data_r, k;
  logic [15:0] mpu_store_addr, dbg_read_addr, prog_addr;
  logic [17:0] dbg_write_addr, flash_rd_addr_r, flash_wr_addr_r;
  logic [5:0]  dbg_page, flash_erase_page_r, pg;
  logic [2:0]  upper_bank_select;
  logic        sfr_hit, dbg_read_valid_r, flash_wr_en_r, flash_mass_erase_r;
  logic        flash_page_erase_r, early_boot_window_flag, code_protection_bit;
  logic        program_write_enable, busy_write_collision_irq, dbg_enabled;
  logic        dbg_ctrl_grant, global_erase_done_r;
  int          n_mismatch, comparisons, cycles, n, r;
  fesb_flash_ctrl uut (.*);
  fesb_flash_model flash (.clock(clock), .rd_addr(flash_rd_addr_r),
    .mass_erase(flash_mass_erase_r), .rd_data(flash_rd_data));
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  function automatic logic [17:0] map(input logic [15:0] a, input logic [2:0] b);
    return a[15] ? {b, a[14:0]} : {3'h0, a[14:0]};
  endfunction
  // contents that the flash model holds before any erase
  function automatic logic [7:0] content(input logic [17:0] p);
    return p[7:0] ^ p[17:10];
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int c = 1);
    repeat (c) @(posedge clock);
    #1;
  endtask
  task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_we = 1'b1;
    tick();
    sfr_we = 1'b0;
  endtask
  task automatic do_reset;
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
  endtask
  task give_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cycles++;
    // whole run needs about 230 cycles
    if (cycles == 1000)
    begin
      n_mismatch++;
      give_verdict;
    end
  end
  initial
  begin
    {sfr_addr, sfr_wdata, sfr_we, sfr_re, upper_bank_select, code_protection_we,
     code_protection_wdata, program_write_enable_we, program_write_enable_wdata,
     mpu_int_enabled, mpu_store, mpu_store_addr, mpu_store_data, engine_busy,
     dbg_mass_erase_req, dbg_page_erase_req, dbg_page, dbg_write_req, dbg_write_addr,
     dbg_write_data, dbg_read_req, dbg_read_addr, dbg_ctrl_req, prog_addr} = '0;
    dbg_port_enable_pin = 1'b1;
    r = $urandom(63);
    do_reset;
    n = 0;
    while (early_boot_window_flag === 1'b1 && n < 100)
    begin
      chk(dbg_enabled, 0);
      tick();
      n++;
    end
    chk(n, 60);
    chk(dbg_enabled, 1);
    for (int i = 0; i < 8; i++)
    begin
      prog_addr = $urandom;
      prog_addr[15] = ~i[0];
      upper_bank_select = i;
      tick();
      chk(flash_rd_addr_r, map(prog_addr, upper_bank_select));
    end
    {dbg_page_erase_req, dbg_page, dbg_ctrl_req} = {1'b1, 6'($urandom), 1'b1};
    {dbg_write_req, dbg_write_addr, dbg_write_data} = {1'b1, 18'($urandom), 8'($urandom)};
    tick();
    chk(dbg_ctrl_grant, 1);
    chk({flash_page_erase_r, flash_erase_page_r}, {1'b1, dbg_page});
    chk({flash_wr_en_r, flash_wr_addr_r, flash_wr_data_r},
        {1'b1, dbg_write_addr, dbg_write_data});
    {dbg_page_erase_req, dbg_write_req, dbg_ctrl_req} = 3'h0;
    {dbg_read_req, dbg_read_addr} = {1'b1, 16'($urandom)};
    k = content(map(dbg_read_addr, upper_bank_select));
    tick();
    dbg_read_req = 1'b0;
    tick();
    chk({dbg_read_valid_r, dbg_read_data_r}, {1'b1, k});
    pg = $urandom_range(63, 1);
    sfr_w(8'hB7, {pg, 2'h0});
    sfr_w(8'h94, 8'h55);
    chk(flash_page_erase_r, 1);
    chk(flash_erase_page_r, pg);
    sfr_addr = 8'hB7;
    sfr_re = 1'b1;
    tick();
    sfr_re = 1'b0;
    chk(sfr_rdata_r, {pg, 2'h0});
    k = $urandom;
    if (k == 8'hAA || k == 8'h55)
      k = 8'h5A;
    sfr_w(8'hB2, 8'h02);
    sfr_w(8'h94, k);
    chk({flash_mass_erase_r, flash_page_erase_r}, 0);
    chk(sfr_hit, 1);
    dbg_port_enable_pin = 1'b0;
    tick(3);
    sfr_w(8'h94, 8'hAA);
    chk(flash_mass_erase_r, 0);
    dbg_port_enable_pin = 1'b1;
    code_protection_we = 1'b1;
    tick();
    chk(code_protection_bit, 0);
    code_protection_wdata = 1'b1;
    tick();
    code_protection_we = 1'b0;
    code_protection_wdata = 1'b0;
    chk(code_protection_bit, 1);
    sfr_w(8'hB7, 8'h00);
    sfr_w(8'h94, 8'h55);
    chk(flash_page_erase_r, 0);
    {program_write_enable_we, program_write_enable_wdata, mpu_int_enabled} = 3'h7;
    tick();
    chk(program_write_enable, 0);
    mpu_int_enabled = 1'b0;
    tick();
    program_write_enable_we = 1'b0;
    chk(program_write_enable, 1);
    {mpu_store, mpu_store_addr, mpu_store_data} = {1'b1, 16'h0400, 8'($urandom)};
    tick();
    chk({flash_wr_en_r, flash_wr_addr_r, flash_wr_data_r},
        {1'b1, 18'h00400, mpu_store_data});
    mpu_store_addr = 16'h0010;
    tick();
    chk(flash_wr_en_r, 0);
    {engine_busy, mpu_store_addr} = {1'b1, 16'h0800};
    tick();
    {engine_busy, mpu_store} = 2'h0;
    chk({busy_write_collision_irq, flash_wr_en_r}, 2'h2);
    {dbg_read_req, dbg_read_addr, dbg_ctrl_req} = {1'b1, 16'h0123, 1'b1};
    {dbg_page_erase_req, dbg_page, dbg_write_req, dbg_write_addr} = {1'b1, 6'h00, 1'b1, 18'h00010};
    tick();
    chk(dbg_ctrl_grant, 0);
    chk({flash_page_erase_r, flash_wr_en_r}, 2'h0);
    {dbg_read_req, dbg_ctrl_req, dbg_page_erase_req, dbg_write_req} = 4'h0;
    tick();
    chk({dbg_read_valid_r, dbg_read_data_r}, 9'h1FF);
    dbg_mass_erase_req = 1'b1;
    tick();
    dbg_mass_erase_req = 1'b0;
    chk({flash_mass_erase_r, global_erase_done_r}, 2'h3);
    tick();
    chk(code_protection_bit, 1);
    do_reset;
    chk(code_protection_bit, 0);
    tick(62);
    sfr_w(8'hB2, 8'h02);
    sfr_w(8'h94, 8'hAA);
    chk(flash_mass_erase_r, 1);
    {dbg_read_req, dbg_read_addr} = {1'b1, 16'($urandom)};
    tick();
    dbg_read_req = 1'b0;
    tick();
    chk({dbg_read_valid_r, dbg_read_data_r}, 9'h1FF);
    do_reset;
    {code_protection_we, code_protection_wdata} = 2'h3;
    tick();
    {code_protection_we, code_protection_wdata} = 2'h0;
    chk({early_boot_window_flag, code_protection_bit}, 2'h3);
    tick(60);
    dbg_ctrl_req = 1'b1;
    tick();
    chk({early_boot_window_flag, dbg_enabled, dbg_ctrl_grant}, 3'h2);
    dbg_ctrl_req = 1'b0;
    give_verdict;
  end
endmodule // test_flash_erase_bank_security
bind fesb_flash_ctrl fesb_checker chk_i (.*);
